//--- verilog/asu_pkg.sv
// constants and register map of the attribute setup stage
//
// Functional notes
// - up to 32 output attributes, position excluded
// - input count comes from read length
// - output count picks lower or upper group
// - one enable swizzles sixteen attributes together
// - two-bit select, four source choices
// - selects encoded zero to three in order
// - back-facing reads next input attribute
// - W-to-X copies source W into X
// - five-bit index, zero follows position
// - constant source 0000, 0001 or 1111
// - per-channel override takes constant channel
// - constant mode: provoking value, zero deltas
// - linear mode: a0, a1-a0, a2-a0
// - wrap shortest folds deltas by one
// - constant mode ignores wrap enables
// - point corners copy center attributes
// - sprite mask picks replaced attributes
// - sprite corner coordinates follow origin
// - statistics count every received object
package asu_pkg;
   // ============================================================
   // register byte offsets
   localparam logic [7:0]  ASU_OFS_CTRL    = 8'h00; // count, enables, origin
   localparam logic [7:0]  ASU_OFS_RDLEN   = 8'h04; // vertex read length
   localparam logic [7:0]  ASU_OFS_CINTERP = 8'h08; // constant interp mask
   localparam logic [7:0]  ASU_OFS_SPRITE  = 8'h0C; // sprite coordinate mask
   localparam logic [7:0]  ASU_OFS_WRAP0   = 8'h10; // wrap enables attr 0-7
   localparam logic [7:0]  ASU_OFS_WRAP1   = 8'h14; // wrap enables attr 8-15
   localparam logic [7:0]  ASU_OFS_STATS   = 8'h18; // object counter
   localparam logic [7:0]  ASU_OFS_STATUS  = 8'h1C; // busy, attr index
   localparam logic [7:0]  ASU_OFS_SWZ     = 8'h40; // 16 swizzle words
   // ============================================================
   // control field positions
   localparam int ASU_CTRL_CNT_LSB = 0;  // 6-bit output count
   localparam int ASU_CTRL_SWZEN   = 6;  // swizzle enable
   localparam int ASU_CTRL_ORIGIN  = 7;  // 0 top-left, 1 bottom-left
   localparam int ASU_CTRL_STATEN  = 8;  // statistics enable
   localparam int ASU_CTRL_W       = 9;
   // swizzle word fields
   localparam int ASU_SWZ_SRC_LSB  = 0;  // 5-bit source index
   localparam int ASU_SWZ_SEL_LSB  = 5;  // 2-bit select
   localparam int ASU_SWZ_CST_LSB  = 7;  // 2-bit constant source
   localparam int ASU_SWZ_OVR_LSB  = 9;  // 4-bit override XYZW
   localparam int ASU_SWZ_W        = 13;
   // ============================================================
   // reset values and limits
   localparam logic [ASU_CTRL_W-1:0] ASU_CTRL_RST = 9'h000;
   localparam logic [5:0]  ASU_MAX_ATTR = 6'h20; // 32 attributes
   localparam logic [5:0]  ASU_GRP_SIZE = 6'h10; // 16 per group
   // fixed point s15.16 component values
   localparam logic [31:0] ASU_ONE  = 32'h0001_0000;
   localparam logic [31:0] ASU_HALF = 32'h0000_8000;
   // ============================================================
   // swizzle selects and constant sources
   typedef enum logic [1:0] {
      SWZ_PLAIN_SOURCE  = 2'h0,
      SWZ_FACING_SOURCE = 2'h1,
      SWZ_W_TO_X        = 2'h2,
      SWZ_FACING_W_TO_X = 2'h3
   } asu_sel_t;
   typedef enum logic [1:0] {
      CST_0000 = 2'h0,
      CST_0001 = 2'h1,
      CST_1111 = 2'h2
   } asu_cst_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN  = 1'b1
   } asu_state_t;
endpackage

//--- verilog/asu_setup.sv
// attribute setup stage: swizzle, override, coefficients, sprites, statistics
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/10ps
module asu_setup (
   input  wire logic         clk_sys_i,
   input  wire logic         nrst_i,
   // ahb-lite slave
   input  wire logic         hsel_i,
   input  wire logic [31:0]  haddr_i,
   input  wire logic [1:0]   htrans_i,
   input  wire logic         hwrite_i,
   input  wire logic [2:0]   hsize_i,
   input  wire logic [31:0]  hwdata_i,
   input  wire logic         hready_i,
   output logic      [31:0]  hrdata_o,
   output logic              hreadyout_o,
   output logic              hresp_o,
   // vertex attribute load
   input  wire logic         vtx_valid_i,
   input  wire logic [1:0]   vtx_sel_i,
   input  wire logic [4:0]   vtx_attr_i,
   input  wire logic [127:0] vtx_data_i,
   output logic              vtx_ready_o,
   // object start from clip stage
   input  wire logic         obj_valid_i,
   input  wire logic         obj_point_i,
   input  wire logic         obj_back_i,
   input  wire logic [1:0]   obj_prov_i,
   output logic              obj_ready_o,
   // coefficient stream to windower
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic      [4:0]   out_attr_o,
   output logic      [1:0]   out_corner_o,
   output logic              out_point_o,
   output logic              out_last_o,
   output logic      [127:0] out_a0_o,
   output logic      [127:0] out_a1_o,
   output logic      [127:0] out_a2_o
);
   import asu_pkg::*;

   // ============================================================
   // storage
   logic [127:0]          vmem_r [0:2][0:31];  // three vertices of input attributes
   logic [ASU_CTRL_W-1:0] ctrl_r;              // control word
   logic [4:0]            rdlen_r;             // read length in attribute pairs
   logic [31:0]           cinterp_r;           // constant interpolation mask
   logic [31:0]           sprite_r;            // sprite coordinate mask
   logic [63:0]           wrap_r;              // wrap enables, 4 per lower attr
   logic [31:0]           stats_r;             // clipper object counter
   logic [ASU_SWZ_W-1:0]  swz_r [0:15];        // per-attribute swizzle words
   asu_state_t            state_r;             // run state
   logic [4:0]            attr_r;              // current output attribute
   logic [1:0]            corner_r;            // current point corner
   logic                  point_r;             // object is a point
   logic                  back_r;              // object faces back
   logic [1:0]            prov_r;              // provoking vertex
   logic                  idle_r;              // ready for loads and objects
   // bus address phase capture
   logic [7:0]            baddr_r;
   logic                  bwr_r;

   // ============================================================
   // helpers
   // value of one input attribute, zero past the input range
   function automatic logic [127:0] rd_attr(input logic [1:0] v, input logic [5:0] idx,
                                            input logic [5:0] n_in);
      rd_attr = 128'h0;
      if (idx < n_in) begin
         rd_attr = vmem_r[v][idx[4:0]];
      end
   endfunction

   // W-to-X copy then per-channel constant override
   function automatic logic [127:0] shape(input logic [127:0] val, input logic [1:0] sel,
                                          input logic [1:0] cst, input logic [3:0] ovr);
      logic [127:0] c;
      shape = val;
      c = 128'h0;
      if (sel[1]) begin
         shape[31:0] = val[127:96];
      end
      case (cst)
         CST_0000: c = 128'h0;
         CST_0001: c = {ASU_ONE, 96'h0};
         default:  c = {4{ASU_ONE}};
      endcase
      for (int k = 0; k < 4; k++) begin
         if (ovr[k]) begin
            shape[k*32 +: 32] = c[k*32 +: 32];
         end
      end
   endfunction

   // fold a delta by one when wrap shortest is on
   function automatic logic [31:0] wrapd(input logic [31:0] d, input logic en);
      wrapd = d;
      if (en && ($signed(d) <= -$signed(ASU_HALF))) begin
         wrapd = d + ASU_ONE;
      end else if (en && ($signed(d) >= $signed(ASU_HALF))) begin
         wrapd = d - ASU_ONE;
      end
   endfunction

   // ============================================================
   // configuration decode
   wire [5:0]  cnt_raw  = ctrl_r[ASU_CTRL_CNT_LSB +: 6];
   wire [5:0]  out_cnt  = (cnt_raw > ASU_MAX_ATTR) ? ASU_MAX_ATTR : cnt_raw;
   wire [5:0]  in_cnt   = ({rdlen_r, 1'b0} > ASU_MAX_ATTR) ? ASU_MAX_ATTR
                                                           : {rdlen_r, 1'b0};
   wire        grp_hi   = out_cnt > ASU_GRP_SIZE;
   wire        swz_on   = ctrl_r[ASU_CTRL_SWZEN] && (attr_r[4] == grp_hi);
   wire [ASU_SWZ_W-1:0] swz_w = swz_r[attr_r[3:0]];
   wire [1:0]  sel      = swz_on ? swz_w[ASU_SWZ_SEL_LSB +: 2] : SWZ_PLAIN_SOURCE;
   wire [4:0]  src      = swz_on ? swz_w[ASU_SWZ_SRC_LSB +: 5] : attr_r;
   wire [1:0]  cst      = swz_w[ASU_SWZ_CST_LSB +: 2];
   wire [3:0]  ovr      = swz_on ? swz_w[ASU_SWZ_OVR_LSB +: 4] : 4'h0;
   wire [5:0]  src_idx  = {1'b0, src} + {5'h00, back_r & sel[0]};

   // ============================================================
   // datapath: swizzled values feed the coefficients
   wire [127:0] v0s = shape(rd_attr(2'h0, src_idx, in_cnt), sel, cst, ovr);
   wire [127:0] v1s = shape(rd_attr(2'h1, src_idx, in_cnt), sel, cst, ovr);
   wire [127:0] v2s = shape(rd_attr(2'h2, src_idx, in_cnt), sel, cst, ovr);
   wire [127:0] pvs = (prov_r == 2'h2) ? v2s : (prov_r == 2'h1) ? v1s : v0s;
   wire         ci  = cinterp_r[attr_r];
   wire [3:0]   wen = (!attr_r[4] && !ci) ? wrap_r[attr_r[3:0]*4 +: 4] : 4'h0;
   logic [127:0] lin_a1;
   logic [127:0] lin_a2;
   generate
      for (genvar k = 0; k < 4; k++) begin : g_comp
         assign lin_a1[k*32 +: 32] = wrapd(v1s[k*32 +: 32] - v0s[k*32 +: 32], wen[k]);
         assign lin_a2[k*32 +: 32] = wrapd(v2s[k*32 +: 32] - v0s[k*32 +: 32], wen[k]);
      end
   endgenerate
   // sprite corner: bit0 right, bit1 bottom; origin flips rows
   wire         spr_x   = corner_r[0];
   wire         spr_y   = corner_r[1] ^ ctrl_r[ASU_CTRL_ORIGIN];
   wire [127:0] spr_val = {ASU_ONE, 32'h0, spr_y ? ASU_ONE : 32'h0,
                           spr_x ? ASU_ONE : 32'h0};
   wire [127:0] pt_val  = sprite_r[attr_r] ? spr_val : v0s;
   wire [127:0] a0_nxt  = point_r ? pt_val : (ci ? pvs : v0s);
   wire [127:0] a1_nxt  = (point_r || ci) ? 128'h0 : lin_a1;
   wire [127:0] a2_nxt  = (point_r || ci) ? 128'h0 : lin_a2;

   // ============================================================
   // sequencing
   wire obj_acc   = obj_valid_i && idle_r;
   wire advance   = (state_r == ST_RUN) && (!out_valid_o || out_ready_i);
   wire attr_end  = !point_r || (corner_r == 2'h3);
   wire obj_end   = attr_end && ({1'b0, attr_r} == out_cnt - 6'h01);
   wire empty_obj = (out_cnt == 6'h00);
   asu_state_t state_nxt;
   assign state_nxt = (state_r == ST_IDLE) ? ((obj_acc && !empty_obj) ? ST_RUN : ST_IDLE)
                    : ((advance && obj_end) ? ST_IDLE : ST_RUN);

   // state, counters and object capture
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         state_r  <= ST_IDLE;
         idle_r   <= 1'b0;
         attr_r   <= 5'h00;
         corner_r <= 2'h0;
         point_r  <= 1'b0;
         back_r   <= 1'b0;
         prov_r   <= 2'h0;
      end else begin
         state_r <= state_nxt;
         idle_r  <= (state_nxt == ST_IDLE);
         if (obj_acc) begin
            attr_r   <= 5'h00;
            corner_r <= 2'h0;
            point_r  <= obj_point_i;
            back_r   <= obj_back_i;
            prov_r   <= obj_prov_i;
         end else if (advance) begin
            corner_r <= point_r ? corner_r + 2'h1 : 2'h0;
            if (attr_end) begin
               attr_r <= attr_r + 5'h01;
            end
         end
      end
   end

   // output registers hold until taken
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         out_valid_o  <= 1'b0;
         out_attr_o   <= 5'h00;
         out_corner_o <= 2'h0;
         out_point_o  <= 1'b0;
         out_last_o   <= 1'b0;
         out_a0_o     <= 128'h0;
         out_a1_o     <= 128'h0;
         out_a2_o     <= 128'h0;
      end else if (advance) begin
         out_valid_o  <= 1'b1;
         out_attr_o   <= attr_r;
         out_corner_o <= corner_r;
         out_point_o  <= point_r;
         out_last_o   <= obj_end;
         out_a0_o     <= a0_nxt;
         out_a1_o     <= a1_nxt;
         out_a2_o     <= a2_nxt;
      end else if (out_ready_i) begin
         out_valid_o  <= 1'b0;
      end
   end

   // vertex loads land only while idle
   always_ff @(posedge clk_sys_i) begin
      if (vtx_valid_i && idle_r && (vtx_sel_i != 2'h3)) begin
         vmem_r[vtx_sel_i][vtx_attr_i] <= vtx_data_i;
      end
   end
   assign vtx_ready_o = idle_r;
   assign obj_ready_o = idle_r;

   // ============================================================
   // ahb-lite slave, zero wait states
   wire addr_ok = hsel_i && htrans_i[1] && hready_i;
   wire wr_dp   = bwr_r;
   wire is_swz  = (baddr_r[7:6] == 2'h1);
   wire stat_wr = wr_dp && (baddr_r == ASU_OFS_STATS);
   wire stat_inc = obj_acc && ctrl_r[ASU_CTRL_STATEN];
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (haddr_i[7:6] == 2'h1) begin
         rd_mux = {19'h0, swz_r[haddr_i[5:2]]};
      end else begin
         case (haddr_i[7:0])
            ASU_OFS_CTRL:    rd_mux = {23'h0, ctrl_r};
            ASU_OFS_RDLEN:   rd_mux = {27'h0, rdlen_r};
            ASU_OFS_CINTERP: rd_mux = cinterp_r;
            ASU_OFS_SPRITE:  rd_mux = sprite_r;
            ASU_OFS_WRAP0:   rd_mux = wrap_r[31:0];
            ASU_OFS_WRAP1:   rd_mux = wrap_r[63:32];
            ASU_OFS_STATS:   rd_mux = stats_r;
            ASU_OFS_STATUS:  rd_mux = {26'h0, attr_r, state_r == ST_RUN};
            default:         rd_mux = 32'h0;
         endcase
      end
   end

   // bus phase capture and read data
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         baddr_r     <= 8'h00;
         bwr_r       <= 1'b0;
         hrdata_o    <= 32'h0;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end else begin
         baddr_r     <= haddr_i[7:0];
         bwr_r       <= addr_ok && hwrite_i;
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
         if (addr_ok && !hwrite_i) begin
            hrdata_o <= rd_mux;
         end
      end
   end

   // register writes in the data phase
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ctrl_r    <= ASU_CTRL_RST;
         rdlen_r   <= 5'h00;
         cinterp_r <= 32'h0;
         sprite_r  <= 32'h0;
         wrap_r    <= 64'h0;
         stats_r   <= 32'h0;
         for (int i = 0; i < 16; i++) begin
            swz_r[i] <= '0;
         end
      end else begin
         if (wr_dp && baddr_r == ASU_OFS_CTRL)    ctrl_r    <= hwdata_i[ASU_CTRL_W-1:0];
         if (wr_dp && baddr_r == ASU_OFS_RDLEN)   rdlen_r   <= hwdata_i[4:0];
         if (wr_dp && baddr_r == ASU_OFS_CINTERP) cinterp_r <= hwdata_i;
         if (wr_dp && baddr_r == ASU_OFS_SPRITE)  sprite_r  <= hwdata_i;
         if (wr_dp && baddr_r == ASU_OFS_WRAP0)   wrap_r[31:0]  <= hwdata_i;
         if (wr_dp && baddr_r == ASU_OFS_WRAP1)   wrap_r[63:32] <= hwdata_i;
         if (wr_dp && is_swz)   swz_r[baddr_r[5:2]] <= hwdata_i[ASU_SWZ_W-1:0];
         // a clearing write still keeps a count event of the same cycle
         if (stat_wr) begin
            stats_r <= stat_inc ? 32'h1 : 32'h0;
         end else if (stat_inc) begin
            stats_r <= stats_r + 32'h1;
         end
      end
   end

   // ============================================================
   // checks
   const_coef_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      advance && !point_r && ci |=> out_a1_o == 128'h0 && out_a2_o == 128'h0)
      else $error("constant attribute has nonzero deltas");
   stats_inc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      obj_acc && ctrl_r[ASU_CTRL_STATEN] && !stat_wr |=> stats_r == $past(stats_r) + 32'h1)
      else $error("object not counted");
   stats_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      !obj_acc && !stat_wr |=> $stable(stats_r))
      else $error("counter moved without object");
   sprite_w_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      advance && point_r && sprite_r[attr_r] |=> out_a0_o[127:96] == ASU_ONE
      && out_a0_o[95:64] == 32'h0)
      else $error("sprite z or w wrong");
   sprite_row_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      advance && point_r && sprite_r[attr_r] && corner_r == 2'h0 && !ctrl_r[ASU_CTRL_ORIGIN]
      |=> out_a0_o[63:0] == 64'h0)
      else $error("top-left sprite corner wrong");
   out_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_a0_o) && $stable(out_attr_o))
      else $error("output changed while stalled");
   // beats never name an attribute beyond the configured output count
   attr_bound_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      out_valid_o |-> {1'b0, out_attr_o} < out_cnt)
      else $error("attribute index out of range");
   ctrl_write_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      addr_ok && hwrite_i && haddr_i[7:0] == ASU_OFS_CTRL ##1 1'b1
      |=> ctrl_r == $past(hwdata_i[ASU_CTRL_W-1:0]))
      else $error("control write lost");
   busy_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
      // a one-beat object frees the port right after its only beat
      obj_acc && !empty_obj |=> !obj_ready_o ##1 (!obj_ready_o || out_last_o))
      else $error("object taken while busy");
endmodule

//--- test/asu_wnd_sink.sv
// windower-side sink model for the coefficient stream
`timescale 1ns/10ps
module asu_wnd_sink (
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   input  wire logic stall_i,
   output logic      out_ready_o
);
   logic [7:0] lfsr_r; // stall pattern source
   // ============================================================
   // ready pattern: steady when stalls are off, irregular otherwise
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         lfsr_r      <= 8'hA5;
         out_ready_o <= 1'b0;
      end else begin
         lfsr_r      <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
         out_ready_o <= !stall_i || lfsr_r[0];
      end
   end
endmodule

//--- test/test_asu_setup.sv
// self-checking bench for the attribute setup stage
`timescale 1ns/10ps
module test_asu_setup;
   import asu_pkg::*;
   typedef struct packed {
      logic [4:0] attr; logic [1:0] corner; logic pt; logic last;
      logic [127:0] a0; logic [127:0] a1; logic [127:0] a2;
   } asu_beat_t;
   logic         clk = 1'b0;    // system clock
   logic         nrst = 1'b0;   // reset, active low
   logic         stall = 1'b0;  // sink stall enable
   logic [31:0]  haddr = 32'h0;
   logic [1:0]   htrans = 2'h0;
   logic         hwrite = 1'b0;
   logic [31:0]  hwdata = 32'h0;
   logic [31:0]  hrdata;
   logic         hready;
   logic         hresp;         // slave response, always okay
   logic         vvalid = 1'b0;
   logic [1:0]   vsel = 2'h0;
   logic [4:0]   vattr = 5'h0;
   logic [127:0] vdata = 128'h0;
   logic         vready;
   logic         ovalid = 1'b0;
   logic         opoint = 1'b0;
   logic         oback = 1'b0;
   logic [1:0]   oprov = 2'h0;
   logic         oready;
   logic         qvalid, qready, qpoint, qlast;
   logic [4:0]   qattr;
   logic [1:0]   qcorner;
   logic [127:0] qa0, qa1, qa2;
   logic [31:0]  cfg [8];       // register mirror, offset / 4
   logic [12:0]  swz [16];      // swizzle word mirror
   logic [127:0] vmem [3][32];  // vertex memory mirror
   asu_beat_t    expq [$];      // expected beats
   logic [31:0]  rexp [$];      // expected read data
   logic         rd_pend = 1'b0;
   int           err_count = 0;
   int           checks_done = 0;
   int           objs = 0;      // objects expected in the counter

   always #10 clk = ~clk;

   asu_setup dut (.clk_sys_i(clk), .nrst_i(nrst), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .vtx_valid_i(vvalid), .vtx_sel_i(vsel), .vtx_attr_i(vattr), .vtx_data_i(vdata),
      .vtx_ready_o(vready), .obj_valid_i(ovalid), .obj_point_i(opoint),
      .obj_back_i(oback), .obj_prov_i(oprov), .obj_ready_o(oready),
      .out_valid_o(qvalid), .out_ready_i(qready), .out_attr_o(qattr),
      .out_corner_o(qcorner), .out_point_o(qpoint), .out_last_o(qlast),
      .out_a0_o(qa0), .out_a1_o(qa1), .out_a2_o(qa2));
   asu_wnd_sink sink (.clk_sys_i(clk), .nrst_i(nrst), .stall_i(stall), .out_ready_o(qready));

   // ============================================================
   // reporting
   task automatic give_verdict;
      $display("mismatches %0d comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_beat(input asu_beat_t got, input asu_beat_t exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t beat attr %0d corner %0d differs", $time, exp.attr, exp.corner);
      end
   endtask
   // ============================================================
   // bus and load drivers
   task automatic ahb_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d);
      haddr  <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      if (a >= ASU_OFS_SWZ) swz[a[5:2]] = d[12:0];
      else cfg[a[4:2]] = d;
      ahb_cycle(a, 1'b1, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rexp.push_back(e);
      ahb_cycle(a, 1'b0, 32'h0);
   endtask
   task automatic vload(input int v, input int a, input logic [127:0] d);
      vmem[v][a] = d;
      vvalid <= 1'b1;
      vsel   <= v[1:0];
      vattr  <= a[4:0];
      vdata  <= d;
      do @(posedge clk); while (vready !== 1'b1);
   endtask
   // one object: counted if enabled, then wait for idle and drained stream
   task automatic send(input logic pt, input logic bk, input logic [1:0] pv);
      if (cfg[0][ASU_CTRL_STATEN]) objs++;
      ovalid <= 1'b1;
      opoint <= pt;
      oback  <= bk;
      oprov  <= pv;
      do @(posedge clk); while (oready !== 1'b1);
      ovalid <= 1'b0;
      do @(posedge clk); while (oready !== 1'b1 || expq.size() != 0);
   endtask
   // ============================================================
   // reference model
   function automatic logic [127:0] inval(input int v, input int a);
      int n;
      n = (cfg[1][4:0] * 2 > 32) ? 32 : cfg[1][4:0] * 2;
      return (a < n) ? vmem[v][a] : 128'h0;
   endfunction
   function automatic logic [127:0] post(input int v, input int i, input logic bk);
      int g;
      logic [12:0] w;
      logic [127:0] r;
      logic [127:0] c;
      g = (cfg[0][5:0] > 6'h10) ? 16 : 0;
      w = swz[(i - g) & 15];
      r = inval(v, i);
      if (cfg[0][ASU_CTRL_SWZEN] && i >= g && i < g + 16) begin
         r = inval(v, w[4:0] + ((w[5] && bk) ? 1 : 0));
         if (w[6]) r[31:0] = r[127:96];
         c = (w[8:7] == 2'h0) ? 128'h0 : (w[8:7] == 2'h1) ? {ASU_ONE, 96'h0} : {4{ASU_ONE}};
         for (int k = 0; k < 4; k++) if (w[9 + k]) r[32 * k +: 32] = c[32 * k +: 32];
      end
      return r;
   endfunction
   function automatic logic [31:0] dlt(input logic [31:0] b, input logic [31:0] a, input logic w);
      logic signed [31:0] d;
      d = b - a;
      if (w && d <= -$signed(ASU_HALF)) d = d + $signed(ASU_ONE);
      else if (w && d >= $signed(ASU_HALF)) d = d - $signed(ASU_ONE);
      return d;
   endfunction
   function automatic int cnt();
      return (cfg[0][5:0] > 6'h20) ? 32 : int'(cfg[0][5:0]);
   endfunction
   task automatic tri_obj(input logic [1:0] pv, input logic bk);
      asu_beat_t e;
      logic [127:0] p [3];
      logic [3:0] wb;
      for (int i = 0; i < cnt(); i++) begin
         for (int v = 0; v < 3; v++) p[v] = post(v, i, bk);
         wb = (i < 8) ? cfg[4][4 * i +: 4] : (i < 16) ? cfg[5][4 * (i - 8) +: 4] : 4'h0;
         e = '{5'(i), 2'h0, 1'b0, 1'(i == cnt() - 1), p[0], 128'h0, 128'h0};
         if (cfg[2][i]) e.a0 = p[pv];
         else for (int k = 0; k < 4; k++) begin
            e.a1[32 * k +: 32] = dlt(p[1][32 * k +: 32], p[0][32 * k +: 32], wb[k]);
            e.a2[32 * k +: 32] = dlt(p[2][32 * k +: 32], p[0][32 * k +: 32], wb[k]);
         end
         expq.push_back(e);
      end
      send(1'b0, bk, pv);
   endtask
   task automatic pt_obj(input logic bk);
      asu_beat_t e;
      for (int i = 0; i < cnt(); i++) for (int c = 0; c < 4; c++) begin
         e = '{5'(i), 2'(c), 1'b1, 1'(i == cnt() - 1 && c == 3), post(0, i, bk), 128'h0, 128'h0};
         if (cfg[3][i]) e.a0 = {ASU_ONE, 32'h0, (c[1] ^ cfg[0][ASU_CTRL_ORIGIN]) ? ASU_ONE : 32'h0,
            c[0] ? ASU_ONE : 32'h0};
         expq.push_back(e);
      end
      send(1'b1, bk, 2'h0);
   endtask
   // ============================================================
   // result monitor: read data in its data phase, beats when accepted
   always @(posedge clk) begin
      // an error response flips bit 0 so it can never pass unseen
      if (rd_pend && hready) cmp_reg(hrdata ^ {31'h0, hresp}, rexp.pop_front());
      rd_pend <= nrst && htrans[1] && !hwrite && hready;
      if (qvalid === 1'b1 && qready === 1'b1) begin
         if (expq.size() == 0) begin
            err_count++;
            $display("BAD %0t unexpected beat", $time);
         end else cmp_beat({qattr, qcorner, qpoint, qlast, qa0, qa1, qa2}, expq.pop_front());
      end
   end
   // watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("BAD %0t watchdog expired", $time);
      give_verdict;
   end
   // ============================================================
   // main sequence
   initial begin
      void'($urandom(51));
      for (int i = 0; i < 16; i++) swz[i] = 13'h0;
      for (int i = 0; i < 8; i++) cfg[i] = 32'h0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(ASU_OFS_CTRL, 32'h0);
      rd(8'h30, 32'h0);
      wr(ASU_OFS_RDLEN, 32'h10);
      for (int v = 0; v < 3; v++) for (int a = 0; a < 32; a++)
         vload(v, a, {$urandom & 32'hFFFF, $urandom & 32'hFFFF, $urandom & 32'hFFFF, $urandom});
      vvalid <= 1'b0;
      // interpolation modes with a prompt sink
      wr(ASU_OFS_CTRL, 32'h10);
      wr(ASU_OFS_CINTERP, $urandom);
      wr(ASU_OFS_WRAP0, $urandom);
      wr(ASU_OFS_WRAP1, $urandom);
      for (int t = 0; t < 3; t++) tri_obj(t[1:0], t[0]);
      stall <= 1'b1;
      // every select code and constant source, index never 31
      for (int i = 0; i < 16; i++)
         wr(ASU_OFS_SWZ + 8'(4 * i), {19'h0, 4'($urandom), 2'(i / 4 % 3), 2'(i % 4), 5'($urandom % 31)});
      wr(ASU_OFS_CTRL, 32'h50);
      tri_obj(2'h0, 1'b0);
      tri_obj(2'h1, 1'b1);
      wr(ASU_OFS_CTRL, 32'h68);
      tri_obj(2'h2, 1'b1);
      wr(ASU_OFS_CTRL, 32'h06);
      wr(ASU_OFS_RDLEN, 32'h2);
      tri_obj(2'h0, 1'b0);
      wr(ASU_OFS_RDLEN, 32'h10);
      // sprites with both origins
      wr(ASU_OFS_SPRITE, $urandom | 32'h1); // attr 0 always a sprite
      wr(ASU_OFS_CTRL, 32'h03);
      pt_obj(1'b0);
      wr(ASU_OFS_CTRL, 32'h83);
      pt_obj(1'b1);
      // object counter: clear, count, zero-attribute object, disabled
      wr(ASU_OFS_STATS, 32'h0);
      objs = 0;
      wr(ASU_OFS_CTRL, 32'h101);
      tri_obj(2'h0, 1'b0);
      pt_obj(1'b0);
      wr(ASU_OFS_CTRL, 32'h100);
      tri_obj(2'h0, 1'b0);
      rd(ASU_OFS_STATS, objs);
      wr(ASU_OFS_CTRL, 32'h001);
      tri_obj(2'h0, 1'b0);
      rd(ASU_OFS_STATS, objs);
      repeat (3) @(posedge clk);
      give_verdict;
   end
endmodule
